// ==== design/ext_bus_ctrl.v ====
// external bus strobes, wait states, fetch select and segment port
//
// Behaviour
// [R1] eight segment pins, each with its own direction bit
// [R2] a pin set as input has its driver switched off
// [R3] in address use pin 0 carries the lowest segment line, pin 7 the highest
// [R4] pin 5 may be the can receive input, pin 6 the can transmit output
// [R5] read strobe goes low for every external instruction or data read
// [R6] full-write mode: write strobe low for every external data write
// [R7] low-byte mode: strobe only for low-byte writes, or any write on 8-bit bus
// [R8] with ready enabled, a high ready input adds wait states until it goes low
// [R9] an address latch pulse marks the address phase of each access
// [R10] fetch select low through and after reset selects external code fetch
// [R11] fetch select high at reset selects internal program memory
// [R12] ready is sampled each wait cycle; access ends in first cycle seen low
//
// Design decisions made here: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "ext_bus_map.vh"

module ext_bus_ctrl (
	input wire clock,
	input wire resetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	input wire [7:0] segment_port_in,
	output reg [7:0] segment_port_out,
	output reg [7:0] segment_port_oe_n,
	input wire ready,
	input wire external_fetch_select,
	input wire can_transmit_data,
	output reg can_receive_input,
	output reg read_strobe_n,
	output reg low_byte_store_strobe_n,
	output reg address_latch,
	output reg boot_external
);

	// ----------------------------------------
	// states
	// ----------------------------------------
	localparam [1:0] st_idle = 2'b00;
	localparam [1:0] st_latch = 2'b01;
	localparam [1:0] st_strobe = 2'b10;
	localparam [1:0] st_end = 2'b11;

	// ----------------------------------------
	// functions
	// ----------------------------------------
	// a level from a pin counts only once the second and third stage agree
	function filtered;
		input prev;
		input s2;
		input s3;
		begin
			filtered = (s2 == s3) ? s3 : prev;
		end
	endfunction

	// ----------------------------------------
	// registers
	// ----------------------------------------
	reg [`CFG_WIDTH-1:0] config_bits;
	reg [7:0] direction;
	reg [7:0] port_out;
	reg [23:0] address;
	reg [3:0] command;
	reg [1:0] state;
	reg [7:0] pin_s1;
	reg [7:0] pin_s2;
	reg [7:0] pin_s3;
	reg [7:0] pin_level;
	reg rdy_s1;
	reg rdy_s2;
	reg rdy_s3;
	reg ready_level;
	reg fetch_s1;
	reg fetch_s2;
	reg fetch_s3;
	reg fetch_level;
	reg [2:0] boot_count;
	reg boot_done;
	reg can_tx_s1;
	reg can_tx_s2;
	reg can_tx_s3;
	reg can_tx_level;

	wire access_phase;
	wire setup_phase;
	wire do_write;
	wire busy;
	wire stall;
	wire strobe_mode;
	wire ready_en;
	wire bus_8bit;
	wire seg_addr_en;
	wire can_en;
	reg [31:0] next_rdata;
	reg next_err;
	reg [7:0] next_pin_out;
	reg [7:0] next_oe_n;
	reg write_store;

	assign setup_phase = psel & penable & ~pready;
	assign access_phase = psel & penable & pready;
	assign do_write = access_phase & pwrite;
	assign busy = (state != st_idle);
	assign strobe_mode = config_bits[`CFG_STROBE_MODE];
	assign ready_en = config_bits[`CFG_READY_EN];
	assign bus_8bit = config_bits[`CFG_BUS_8BIT];
	assign seg_addr_en = config_bits[`CFG_SEG_ADDR_EN];
	assign can_en = config_bits[`CFG_CAN_EN];
	// wait states are only honoured while the ready function is on
	assign stall = ready_en & ready_level; // [R8]

	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	always @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			pin_s1 <= 8'h00;
			pin_s2 <= 8'h00;
			pin_s3 <= 8'h00;
			pin_level <= 8'h00;
			rdy_s1 <= 1'b1;
			rdy_s2 <= 1'b1;
			rdy_s3 <= 1'b1;
			ready_level <= 1'b1;
			fetch_s1 <= 1'b1;
			fetch_s2 <= 1'b1;
			fetch_s3 <= 1'b1;
			fetch_level <= 1'b1;
			can_tx_s1 <= 1'b1;
			can_tx_s2 <= 1'b1;
			can_tx_s3 <= 1'b1;
			can_tx_level <= 1'b1;
		end else begin
			pin_s1 <= segment_port_in;
			pin_s2 <= pin_s1;
			pin_s3 <= pin_s2;
			pin_level <= (pin_s2 & pin_s3) | (pin_level & (pin_s2 ^ pin_s3));
			rdy_s1 <= ready;
			rdy_s2 <= rdy_s1;
			rdy_s3 <= rdy_s2;
			ready_level <= filtered(ready_level, rdy_s2, rdy_s3); // [R12]
			fetch_s1 <= external_fetch_select;
			fetch_s2 <= fetch_s1;
			fetch_s3 <= fetch_s2;
			fetch_level <= filtered(fetch_level, fetch_s2, fetch_s3);
			can_tx_s1 <= can_transmit_data;
			can_tx_s2 <= can_tx_s1;
			can_tx_s3 <= can_tx_s2;
			can_tx_level <= filtered(can_tx_level, can_tx_s2, can_tx_s3);
		end
	end

	// ----------------------------------------
	// boot source capture
	// ----------------------------------------
	// the strap is taken a few cycles after release, once the filter has settled
	always @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			boot_count <= 3'h0;
			boot_done <= 1'b0;
			boot_external <= 1'b0;
		end else if (!boot_done) begin
			if (boot_count == `BOOT_SAMPLE_CYCLES) begin
				boot_done <= 1'b1;
				boot_external <= ~fetch_level; // [R10] [R11]
			end else begin
				boot_count <= boot_count + 3'h1;
			end
		end
	end

	// ----------------------------------------
	// apb slave
	// ----------------------------------------
	always @* begin
		next_rdata = 32'h0000_0000;
		next_err = 1'b0;
		case (paddr)
		`OFS_CONFIG: begin
			next_rdata = {27'h000_0000, config_bits};
		end
		`OFS_DIRECTION: begin
			next_rdata = {24'h00_0000, direction};
		end
		`OFS_PORT_OUT: begin
			next_rdata = {24'h00_0000, port_out};
		end
		`OFS_PORT_IN: begin
			next_rdata = {24'h00_0000, pin_level};
		end
		`OFS_ADDRESS: begin
			next_rdata = {8'h00, address};
		end
		`OFS_COMMAND: begin
			next_rdata = {28'h000_0000, command};
		end
		`OFS_STATUS: begin
			next_rdata = {29'h000_0000, ready_level, boot_external, busy};
		end
		default: begin
			next_err = 1'b1;
		end
		endcase
	end

	// one wait state: the answer is registered in the first access cycle
	always @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end else if (setup_phase) begin
			pready <= 1'b1;
			pslverr <= next_err;
			prdata <= pwrite ? 32'h0000_0000 : next_rdata;
		end else begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end
	end

	// ----------------------------------------
	// software registers
	// ----------------------------------------
	always @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			config_bits <= `RST_CONFIG;
			direction <= `RST_DIRECTION;
			port_out <= `RST_PORT_OUT;
			address <= `RST_ADDRESS;
		end else if (do_write) begin
			case (paddr)
			`OFS_CONFIG: begin
				config_bits <= pwdata[`CFG_WIDTH-1:0]; // [R7]
			end
			`OFS_DIRECTION: begin
				direction <= pwdata[7:0]; // [R1]
			end
			`OFS_PORT_OUT: begin
				port_out <= pwdata[7:0];
			end
			`OFS_ADDRESS: begin
				// changing the address mid-access would glitch the segment lines
				if (!busy) begin
					address <= pwdata[23:0];
				end
			end
			default: begin
			end
			endcase
		end
	end

	// ----------------------------------------
	// access sequencer
	// ----------------------------------------
	always @* begin
		if (!command[`CMD_WRITE]) begin
			write_store = 1'b0;
		end else if (!strobe_mode) begin
			write_store = 1'b1; // [R6]
		end else begin
			write_store = bus_8bit | command[`CMD_BYTE_LOW]; // [R7]
		end
	end

	always @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			state <= st_idle;
			command <= 4'h0;
			address_latch <= 1'b0;
			read_strobe_n <= 1'b1;
			low_byte_store_strobe_n <= 1'b1;
		end else begin
			case (state)
			st_idle: begin
				// a command written while busy is dropped, status shows busy
				if (do_write && paddr == `OFS_COMMAND) begin
					command <= pwdata[3:0];
					address_latch <= 1'b1; // [R9]
					state <= st_latch;
				end
			end
			st_latch: begin
				address_latch <= 1'b0;
				read_strobe_n <= command[`CMD_WRITE]; // [R5]
				low_byte_store_strobe_n <= ~write_store;
				state <= st_strobe;
			end
			st_strobe: begin
				// sampled once per cycle; the first low level ends the access
				if (!stall) begin // [R8] [R12]
					read_strobe_n <= 1'b1;
					low_byte_store_strobe_n <= 1'b1;
					state <= st_end;
				end
			end
			st_end: begin
				state <= st_idle;
			end
			default: begin
				state <= st_idle;
			end
			endcase
		end
	end

	// ----------------------------------------
	// segment port drivers
	// ----------------------------------------
	always @* begin
		// address use outranks the port latch on every pin driven as output, except pin 6 while the can function is on
		next_pin_out = seg_addr_en ? address[23:16] : port_out; // [R3]
		next_oe_n = ~direction; // [R1] [R2]
		if (can_en) begin
			next_oe_n[`SEG_CAN_RX_PIN] = 1'b1; // [R4]
			next_pin_out[`SEG_CAN_RX_PIN] = 1'b0;
			next_oe_n[`SEG_CAN_TX_PIN] = 1'b0; // [R4]
			next_pin_out[`SEG_CAN_TX_PIN] = can_tx_level;
		end
	end

	always @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			segment_port_out <= 8'h00;
			segment_port_oe_n <= 8'hFF;
			can_receive_input <= 1'b1;
		end else begin
			segment_port_out <= next_pin_out;
			segment_port_oe_n <= next_oe_n; // [R2]
			// idle recessive level is shown while the can function is off
			can_receive_input <= can_en ? pin_level[`SEG_CAN_RX_PIN] : 1'b1; // [R4]
		end
	end

endmodule
`default_nettype wire

// ==== design/ext_bus_map.vh ====
// register offsets, field positions, reset values and counts of the external bus block
`ifndef EXT_BUS_MAP_VH
`define EXT_BUS_MAP_VH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define OFS_CONFIG 8'h00
`define OFS_DIRECTION 8'h04
`define OFS_PORT_OUT 8'h08
`define OFS_PORT_IN 8'h0C
`define OFS_ADDRESS 8'h10
`define OFS_COMMAND 8'h14
`define OFS_STATUS 8'h18

// ----------------------------------------
// config fields
// ----------------------------------------
`define CFG_STROBE_MODE 0
`define CFG_READY_EN 1
`define CFG_BUS_8BIT 2
`define CFG_SEG_ADDR_EN 3
`define CFG_CAN_EN 4
`define CFG_WIDTH 5

// ----------------------------------------
// command fields
// ----------------------------------------
`define CMD_WRITE 0
`define CMD_FETCH 1
`define CMD_BYTE_LOW 2
`define CMD_BYTE_HIGH 3

// ----------------------------------------
// status fields
// ----------------------------------------
`define STS_BUSY 0
`define STS_BOOT_EXT 1
`define STS_READY 2

// ----------------------------------------
// segment port pins with alternate use
// ----------------------------------------
`define SEG_CAN_RX_PIN 5
`define SEG_CAN_TX_PIN 6

// ----------------------------------------
// reset values and counts
// ----------------------------------------
`define RST_CONFIG 5'h00
`define RST_DIRECTION 8'h00
`define RST_PORT_OUT 8'h00
`define RST_ADDRESS 24'h00_0000
`define BOOT_SAMPLE_CYCLES 3'h4

`endif

// ==== verification/ext_bus_monitor.sv ====
// assertions on the external bus block ports
`timescale 1ns/1ps
`default_nettype none
module ext_bus_monitor (
	input wire clock,
	input wire resetn,
	input wire pready,
	input wire pslverr,
	input wire [31:0] prdata,
	input wire read_strobe_n,
	input wire low_byte_store_strobe_n,
	input wire address_latch,
	input wire boot_external,
	input wire external_fetch_select
);
// ----
// checks
// ----
default clocking @(posedge clock); endclocking
default disable iff (!resetn);
chk_latch_single: assert property (address_latch |=> !address_latch)
	else $error("latch pulse too long");
chk_latch_idle: assert property (address_latch |-> read_strobe_n &&
	low_byte_store_strobe_n)
	else $error("strobe during latch pulse");
chk_read_follows: assert property ($fell(read_strobe_n) |-> $past(address_latch))
	else $error("read strobe without latch");
chk_write_follows: assert property ($fell(low_byte_store_strobe_n) |->
	$past(address_latch))
	else $error("write strobe without latch");
chk_one_strobe: assert property (read_strobe_n || low_byte_store_strobe_n)
	else $error("both strobes low");
chk_boot_strap: assert property ($rose(boot_external) |-> !external_fetch_select)
	else $error("external boot with strap high");
chk_boot_hold: assert property (boot_external |=> boot_external)
	else $error("boot choice changed");
chk_reply_pulse: assert property (pready |=> !pready)
	else $error("reply longer than one cycle");
chk_error_reply: assert property (pslverr |-> pready)
	else $error("error without reply");
chk_data_idle: assert property (!pready |-> prdata == 32'h0000_0000)
	else $error("read data outside reply");
endmodule
`default_nettype wire

// ==== verification/slow_memory.sv ====
// model of a slow external memory answering on the ready pin
`timescale 1ns/1ps
`default_nettype none
module slow_memory (
	input wire logic clock,
	input wire logic read_strobe_n,
	input wire logic low_byte_store_strobe_n,
	input wire logic [3:0] waits,
	output logic ready
);
logic [3:0] held = 4'h0;
// ----
// wait requests
// ----
always @(posedge clock) begin
	if (read_strobe_n && low_byte_store_strobe_n) held <= 4'h0;
	else if (held != 4'hf) held <= held + 4'h1;
end
// ready idles high when slow, since the filter delays what the block sees
assign ready = waits != 4'h0 && held < waits;
endmodule
`default_nettype wire

// ==== verification/test_ext_bus_ctrl.sv ====
// testbench of the external bus block
`timescale 1ns/1ps
`default_nettype none
`include "ext_bus_map.vh"
module test_ext_bus_ctrl;
logic clock = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0;
logic external_fetch_select = 0, can_transmit_data = 0;
logic [7:0] paddr = 0, segment_port_in = 0;
logic [31:0] pwdata = 0, r;
logic [3:0] waits = 0;
logic [15:0] row;
logic [15:0] rows [6] = '{16'h0000, 16'h1106, 16'h0480, 16'h0c80, 16'h1a84, 16'h2c80};
wire [31:0] prdata;
wire [7:0] segment_port_out, segment_port_oe_n;
wire pready, pslverr, ready, can_receive_input, read_strobe_n;
wire low_byte_store_strobe_n, address_latch, boot_external;
logic [32:0] notes [$];
integer num_errors = 0, comparisons = 0, cycles = 0, seed = 32'ha085_9532;
integer i, rd, wr, al;
ext_bus_ctrl dut (.clock(clock), .resetn(resetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .segment_port_in(segment_port_in), .segment_port_out(segment_port_out),
	.segment_port_oe_n(segment_port_oe_n), .ready(ready),
	.external_fetch_select(external_fetch_select), .can_transmit_data(can_transmit_data),
	.can_receive_input(can_receive_input), .read_strobe_n(read_strobe_n),
	.low_byte_store_strobe_n(low_byte_store_strobe_n), .address_latch(address_latch),
	.boot_external(boot_external));
slow_memory mem (.clock(clock), .read_strobe_n(read_strobe_n),
	.low_byte_store_strobe_n(low_byte_store_strobe_n), .waits(waits), .ready(ready));
// ----
// clock, timeout, reply watcher
// ----
initial forever #10 clock = ~clock;
always @(posedge clock) begin
	cycles <= cycles + 1;
	if (cycles > 5000) begin
		num_errors = num_errors + 1;
		give_verdict;
	end
end
always @(posedge clock)
	if (psel && penable && pready) check({pslverr, prdata}, notes.pop_front());
task check(input logic [32:0] seen, input logic [32:0] exp);
	comparisons = comparisons + 1;
	if (seen !== exp) begin
		num_errors = num_errors + 1;
		$display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
	end
endtask
task apb(input logic w_en, input logic [7:0] a, input logic [31:0] d, input logic [32:0] e);
	@(posedge clock);
	psel <= 1;
	penable <= 0;
	pwrite <= w_en;
	paddr <= a;
	pwdata <= d;
	notes.push_back(e);
	@(posedge clock);
	penable <= 1;
	@(posedge clock);
	while (!pready) @(posedge clock);
	psel <= 0;
	penable <= 0;
endtask
// strobe width: exactly one cycle unless the memory stalls, then bounded by filter delay
function automatic logic ok(input integer n, input logic e, input integer w);
	return e ? (w == 0 ? n == 1 : n > w && n <= w + 6) : n == 0;
endfunction
task give_verdict;
	$display("errors %0d comparisons %0d", num_errors, comparisons);
	if (num_errors == 0 && comparisons > 0) $display("Test passed");
	else $display("Test failed");
	$finish;
endtask
// ----
// scenarios
// ----
initial begin
	for (i = 1; i >= 0; i = i - 1) begin
		resetn <= 0;
		external_fetch_select <= i[0];
		repeat (8) @(posedge clock);
		resetn <= 1;
		repeat (12) @(posedge clock);
		check(33'(boot_external), 33'(!i[0]));
	end
	r = $random(seed);
	segment_port_in <= r[31:24];
	apb(0, `OFS_CONFIG, 0, 33'h0);
	apb(0, `OFS_STATUS, 0, 33'h2);
	apb(0, 8'h1c, 0, 33'h1_0000_0000);
	apb(1, `OFS_DIRECTION, r, 33'h0);
	apb(1, `OFS_PORT_OUT, r >> 8, 33'h0);
	apb(0, `OFS_DIRECTION, 0, {25'h0, r[7:0]});
	check({25'h0, segment_port_oe_n}, {25'h0, ~r[7:0]});
	check({25'h0, segment_port_out}, {25'h0, r[15:8]});
	for (i = 0; i < 6; i = i + 1) begin
		row = rows[i];
		apb(1, `OFS_CONFIG, {27'h0, row[15:11]}, 33'h0);
		waits <= row[3:0];
		apb(1, `OFS_COMMAND, {28'h0, row[10:7]}, 33'h0);
		rd = 0;
		wr = 0;
		al = 0;
		repeat (40) begin
			@(posedge clock);
			rd = rd + !read_strobe_n;
			wr = wr + !low_byte_store_strobe_n;
			al = al + address_latch;
		end
		check(33'(ok(rd, !row[7], row[3:0])), 33'h1);
		check(33'(ok(wr, row[7] && (!row[11] || row[13] || row[9]), row[3:0])), 33'h1);
		check(33'(al), 33'h1);
	end
	waits <= 0;
	can_transmit_data <= r[0];
	segment_port_in <= r[31:24] & 8'hdf;
	apb(1, `OFS_DIRECTION, 32'h0000_00ff, 33'h0);
	apb(1, `OFS_ADDRESS, r, 33'h0);
	apb(1, `OFS_CONFIG, 32'h0000_0018, 33'h0);
	apb(0, `OFS_PORT_IN, 0, {25'h0, r[31:24] & 8'hdf});
	repeat (8) @(posedge clock);
	check({25'h0, segment_port_out & 8'h9f}, {25'h0, r[23:16] & 8'h9f});
	check({25'h0, segment_port_oe_n}, 33'h20);
	check(33'({segment_port_out[6], can_receive_input}), 33'({r[0], 1'b0}));
	give_verdict;
end
endmodule
bind ext_bus_ctrl ext_bus_monitor mon (.clock(clock), .resetn(resetn), .pready(pready),
	.pslverr(pslverr), .prdata(prdata), .read_strobe_n(read_strobe_n),
	.low_byte_store_strobe_n(low_byte_store_strobe_n), .address_latch(address_latch),
	.boot_external(boot_external), .external_fetch_select(external_fetch_select));
`default_nettype wire
